// ===== rtl/psm_defs.svh
// constants for the supply management block: addresses, thresholds, timing
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH
`define PSM_CTRL_BASE 8'hB0
`define PSM_EEP_BASE 8'hA0
`define PSM_CMD_INLET 8'h8D
`define PSM_CMD_HEATSINK 8'h8E
`define PSM_CMD_RECT 8'hD6
`define PSM_EEP_BYTES 256
`define PSM_MAX_BLOCK 8'hFF
`define PSM_INLET_WARN_NORM 16'h004D
`define PSM_INLET_SHUT_NORM 16'h0050
`define PSM_INLET_WARN_REV 16'h0043
`define PSM_INLET_SHUT_REV 16'h0046
`define PSM_HOT_WARN 16'h005F
`define PSM_HOT_SHUT 16'h0069
`define PSM_CLK_MHZ 100
`define PSM_SCL_LOW_TOUT_US 25000
`define PSM_STRETCH_MAX_US 1000
`define PSM_SNS_INLET 0
`define PSM_SNS_HEATSINK 1
`define PSM_SNS_RECT 2
`endif

// ===== rtl/psm_pkg.sv
// types shared by the supply management block
package psm_pkg;
    typedef enum logic [2:0] {
        PSM_IDLE, PSM_ADDR, PSM_RX, PSM_ACK, PSM_TX, PSM_ACK_TX
    } psm_state_t;
    typedef struct packed {
        logic [15:0] rectifier;
        logic [15:0] heatsink;
        logic [15:0] inlet;
    } psm_temps_t;
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] data;
        logic [7:0] nbytes;
    } psm_cmd_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } psm_blk_t;
    typedef struct packed {
        logic [2:0] warn;
        logic [2:0] shut;
        logic fan_max;
        logic main_off;
        logic stby_off;
        logic led_amber_solid;
        logic led_amber_blink;
        logic power_good_out;
        logic alert_on;
    } psm_therm_t;
endpackage : psm_pkg

// ===== rtl/psm_thermal.sv
// thermal monitor: thresholds, fan, output disables, indicator and alert state
`timescale 1ns/1ps
`include "psm_defs.svh"
module psm_thermal import psm_pkg::*; #(
    parameter logic [2:0] AUX_MASK = 3'h0
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire psm_temps_t temps_i,
    input wire logic reverse_airflow_i,
    input wire logic ext_warn_i,
    input wire logic ext_shut_i,
    output psm_therm_t therm_o
);
    psm_therm_t therm;
    psm_therm_t next_therm;
    logic [15:0] inlet_warn;
    logic [15:0] inlet_shut;
    logic any_warn;
    logic any_shut;

    always_comb begin
        inlet_warn = reverse_airflow_i ? `PSM_INLET_WARN_REV : `PSM_INLET_WARN_NORM;
        inlet_shut = reverse_airflow_i ? `PSM_INLET_SHUT_REV : `PSM_INLET_SHUT_NORM;
        next_therm = '0;
        next_therm.warn[`PSM_SNS_INLET] = temps_i.inlet >= inlet_warn;
        next_therm.shut[`PSM_SNS_INLET] = temps_i.inlet > inlet_shut;
        next_therm.warn[`PSM_SNS_HEATSINK] = temps_i.heatsink >= `PSM_HOT_WARN;
        next_therm.shut[`PSM_SNS_HEATSINK] = temps_i.heatsink > `PSM_HOT_SHUT;
        next_therm.warn[`PSM_SNS_RECT] = temps_i.rectifier >= `PSM_HOT_WARN;
        next_therm.shut[`PSM_SNS_RECT] = temps_i.rectifier > `PSM_HOT_SHUT;
        any_warn = (|next_therm.warn) | ext_warn_i;
        any_shut = (|next_therm.shut) | ext_shut_i;
        next_therm.fan_max = |next_therm.warn;
        next_therm.main_off = |(next_therm.shut & ~AUX_MASK);
        next_therm.stby_off = |(next_therm.shut & AUX_MASK);
        // all indications leave this one register together
        next_therm.led_amber_solid = any_shut;
        next_therm.led_amber_blink = any_warn & ~any_shut;
        next_therm.power_good_out = ~any_shut;
        next_therm.alert_on = any_warn | any_shut;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            therm <= '0;
        end else begin
            therm <= next_therm;
        end
    end

    assign therm_o = therm;

    a_alert_or: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (ext_warn_i || ext_shut_i || temps_i.heatsink >= `PSM_HOT_WARN) |=> therm.alert_on)
        else $error("alert not raised for an active event");
    a_alert_release: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!ext_warn_i && !ext_shut_i && !(|next_therm.warn) && !(|next_therm.shut))
        |=> !therm.alert_on)
        else $error("alert held with no event left");
    a_led_alert: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        therm.alert_on == (therm.led_amber_solid || therm.led_amber_blink))
        else $error("alert and amber indicator disagree");
    a_fan_warn: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (temps_i.rectifier >= `PSM_HOT_WARN) |=> therm.fan_max)
        else $error("fan not forced to full speed on warning");
    a_inlet_norm: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!reverse_airflow_i && temps_i.inlet == 16'h0051) |=> therm.shut[0])
        else $error("inlet shutdown missed, normal airflow");
    a_inlet_rev: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (reverse_airflow_i && temps_i.inlet == 16'h0043) |=> therm.warn[0] && !therm.shut[0])
        else $error("inlet warning wrong, reverse airflow");
    a_hot_shut: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (temps_i.heatsink == 16'h0069) |=> !therm.shut[1] ##0 therm.warn[1])
        else $error("heat sink shutdown threshold wrong");
endmodule : psm_thermal

// ===== rtl/psm_top.sv
// supply management: serial slave for controller and user memory, alert, thermal
`timescale 1ns/1ps
`include "psm_defs.svh"
module psm_top import psm_pkg::*; #(
    parameter int TOUT_CYCLES = `PSM_SCL_LOW_TOUT_US * `PSM_CLK_MHZ,
    parameter logic [2:0] AUX_MASK = 3'h0
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_sel_bit0_i,
    input wire logic addr_sel_bit1_i,
    input wire logic addr_sel_bit2_i,
    input wire logic in_ok_variant_i,
    input wire logic reverse_airflow_i,
    input wire psm_temps_t temps_i,
    input wire logic ext_warn_i,
    input wire logic ext_shut_i,
    output logic fault_alert_n_o,
    output logic fault_alert_n_oe_o,
    output psm_therm_t therm_o,
    output psm_cmd_t cmd_o,
    output psm_blk_t blk_o
);
    localparam int TW = $clog2(TOUT_CYCLES + 1);
    localparam logic [TW-1:0] TOUT_LAST = TW'(TOUT_CYCLES - 1);

    // pin synchronisers: three stages, filtered value moves when stages 2 and 3 agree
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] filt;
    logic [5:0] next_filt;
    logic [5:0] filt_d;
    always_comb begin
        next_filt = (filt & (sync2 ^ sync3)) | (sync2 & ~(sync2 ^ sync3));
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1 <= 6'h03;
            sync2 <= 6'h03;
            sync3 <= 6'h03;
            filt <= 6'h03;
            filt_d <= 6'h03;
        end else begin
            sync1 <= {in_ok_variant_i, addr_sel_bit2_i, addr_sel_bit1_i, addr_sel_bit0_i,
                sda_i, scl_i};
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= next_filt;
            filt_d <= filt;
        end
    end

    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [2:0] sel;
    logic [7:0] ctrl_addr;
    logic [7:0] eep_addr;
    assign scl_f = filt[0];
    assign sda_f = filt[1];
    assign scl_rise = scl_f & ~filt_d[0];
    assign scl_fall = ~scl_f & filt_d[0];
    assign start_c = scl_f & filt_d[0] & ~sda_f & filt_d[1];
    assign stop_c = scl_f & filt_d[0] & sda_f & ~filt_d[1];
    assign sel = {filt[4] & ~filt[5], filt[3], filt[2]};
    assign ctrl_addr = `PSM_CTRL_BASE + {4'h0, sel, 1'b0};
    assign eep_addr = `PSM_EEP_BASE + {4'h0, sel, 1'b0};

    // user memory, host access only
    logic [7:0] mem [0:`PSM_EEP_BYTES-1];
    logic mem_we;

    psm_state_t st;
    psm_state_t next_st;
    logic [3:0] bcnt;
    logic [3:0] next_bcnt;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic drv;
    logic next_drv;
    logic [7:0] idx;
    logic [7:0] next_idx;
    logic [7:0] code;
    logic [7:0] next_code;
    logic [7:0] eaddr;
    logic [7:0] next_eaddr;
    logic [15:0] wdata;
    logic [15:0] next_wdata;
    logic is_eep;
    logic next_is_eep;
    logic is_rd;
    logic next_is_rd;
    logic hit;
    logic next_hit;
    logic [TW-1:0] tcnt;
    logic [TW-1:0] next_tcnt;
    psm_cmd_t cmd;
    psm_cmd_t next_cmd;
    psm_blk_t blk;
    psm_blk_t next_blk;
    logic [7:0] tx_byte;

    always_comb begin
        next_st = st;
        next_bcnt = bcnt;
        next_sh = sh;
        next_drv = drv;
        next_idx = idx;
        next_code = code;
        next_eaddr = eaddr;
        next_wdata = wdata;
        next_is_eep = is_eep;
        next_is_rd = is_rd;
        next_hit = hit;
        next_cmd = '0;
        next_blk = '0;
        mem_we = 1'b0;
        tx_byte = 8'h00;
        // byte to return: memory location or controller word, low byte first
        if (is_eep) begin
            tx_byte = mem[eaddr];
        end else if (idx < 8'h02) begin
            unique case (code)
                `PSM_CMD_INLET: tx_byte = idx[0] ? temps_i.inlet[15:8] : temps_i.inlet[7:0];
                `PSM_CMD_HEATSINK: tx_byte = idx[0] ? temps_i.heatsink[15:8]
                    : temps_i.heatsink[7:0];
                `PSM_CMD_RECT: tx_byte = idx[0] ? temps_i.rectifier[15:8]
                    : temps_i.rectifier[7:0];
                default: tx_byte = 8'h00;
            endcase
        end
        next_tcnt = scl_f ? '0 : ((tcnt == TOUT_LAST) ? tcnt : tcnt + 1'b1);
        if (!scl_f && tcnt == TOUT_LAST) begin
            next_st = PSM_IDLE;
            next_drv = 1'b0;
            next_hit = 1'b0;
        end else if (start_c) begin
            next_st = PSM_ADDR;
            next_bcnt = 4'h0;
            next_drv = 1'b0;
            next_idx = 8'h00;
            next_hit = 1'b0;
        end else if (stop_c) begin
            next_st = PSM_IDLE;
            next_drv = 1'b0;
            next_hit = 1'b0;
            if (hit && !is_eep && !is_rd && idx != 8'h00) begin
                next_cmd.valid = 1'b1;
                next_cmd.code = code;
                next_cmd.data = wdata;
                next_cmd.nbytes = idx - 8'h01;
            end
        end else if (scl_rise) begin
            unique case (st)
                PSM_ADDR, PSM_RX: begin
                    next_sh = {sh[6:0], sda_f};
                    next_bcnt = bcnt + 4'h1;
                end
                PSM_TX: next_bcnt = bcnt + 4'h1;
                PSM_ACK_TX: if (sda_f) next_st = PSM_IDLE;
                PSM_IDLE, PSM_ACK: next_st = st;
            endcase
        end else if (scl_fall) begin
            unique case (st)
                PSM_ADDR: if (bcnt == 4'h8) begin
                    next_is_rd = sh[0];
                    if ({sh[7:1], 1'b0} == ctrl_addr || {sh[7:1], 1'b0} == eep_addr) begin
                        next_is_eep = ({sh[7:1], 1'b0} == eep_addr);
                        next_hit = 1'b1;
                        next_drv = 1'b1;
                        next_st = PSM_ACK;
                    end else begin
                        next_st = PSM_IDLE;
                    end
                end
                PSM_RX: if (bcnt == 4'h8) begin
                    next_st = PSM_ACK;
                    next_drv = idx != `PSM_MAX_BLOCK;
                    next_idx = (idx == `PSM_MAX_BLOCK) ? idx : idx + 8'h01;
                    if (is_eep) begin
                        if (idx == 8'h01) next_eaddr = sh;
                        if (idx >= 8'h02) begin
                            mem_we = 1'b1;
                            next_eaddr = eaddr + 8'h01;
                        end
                    end else begin
                        unique case (idx)
                            8'h00: next_code = sh;
                            8'h01: next_wdata = {8'h00, sh};
                            8'h02: next_wdata = {sh, wdata[7:0]};
                            default: begin
                                next_blk.valid = 1'b1;
                                next_blk.data = sh;
                            end
                        endcase
                    end
                end
                PSM_ACK, PSM_ACK_TX: begin
                    next_bcnt = 4'h0;
                    if (is_rd) begin
                        next_st = PSM_TX;
                        next_sh = tx_byte;
                        next_drv = ~tx_byte[7];
                        next_idx = (idx == `PSM_MAX_BLOCK) ? idx : idx + 8'h01;
                        if (is_eep) next_eaddr = eaddr + 8'h01;
                    end else begin
                        next_st = PSM_RX;
                        next_drv = 1'b0;
                    end
                end
                PSM_TX: if (bcnt == 4'h8) begin
                    next_drv = 1'b0;
                    next_st = PSM_ACK_TX;
                end else begin
                    next_sh = {sh[6:0], 1'b0};
                    next_drv = ~sh[6];
                end
                PSM_IDLE: next_st = st;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= PSM_IDLE;
            bcnt <= 4'h0;
            sh <= 8'h00;
            drv <= 1'b0;
            idx <= 8'h00;
            code <= 8'h00;
            eaddr <= 8'h00;
            wdata <= 16'h0000;
            is_eep <= 1'b0;
            is_rd <= 1'b0;
            hit <= 1'b0;
            tcnt <= '0;
            cmd <= '0;
            blk <= '0;
        end else begin
            st <= next_st;
            bcnt <= next_bcnt;
            sh <= next_sh;
            drv <= next_drv;
            idx <= next_idx;
            code <= next_code;
            eaddr <= next_eaddr;
            wdata <= next_wdata;
            is_eep <= next_is_eep;
            is_rd <= next_is_rd;
            hit <= next_hit;
            tcnt <= next_tcnt;
            cmd <= next_cmd;
            blk <= next_blk;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (mem_we) begin
            mem[eaddr] <= sh;
        end
    end

    psm_thermal #(.AUX_MASK(AUX_MASK)) u_thermal (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .temps_i(temps_i),
        .reverse_airflow_i(reverse_airflow_i),
        .ext_warn_i(ext_warn_i),
        .ext_shut_i(ext_shut_i),
        .therm_o(therm_o)
    );

    // clock line is never driven, so the device cannot stretch
    assign sda_o = 1'b0;
    assign sda_oe_o = drv;
    assign fault_alert_n_o = 1'b0;
    assign fault_alert_n_oe_o = therm_o.alert_on;
    assign cmd_o = cmd;
    assign blk_o = blk;

    a_alert_pin: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        fault_alert_n_oe_o == (therm_o.led_amber_solid || therm_o.led_amber_blink))
        else $error("alert pin does not follow event state");
    a_scl_timeout: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!scl_f && tcnt == TOUT_LAST && !start_c) |=> st == PSM_IDLE && !sda_oe_o)
        else $error("bus not idle after clock low timeout");
    a_start_reset: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (start_c && scl_f && tcnt != TOUT_LAST) |=> st == PSM_ADDR && bcnt == 4'h0)
        else $error("start did not restart the protocol");
    a_stop_idle: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        stop_c |=> st == PSM_IDLE ##1 !sda_oe_o)
        else $error("stop did not return to idle");
    a_sel2_forced: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        filt[5] |-> ctrl_addr[3] == 1'b0 && eep_addr[3] == 1'b0)
        else $error("select bit two not forced on input-good variant");
    a_word_exec: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (stop_c && hit && !is_eep && !is_rd && idx == 8'h03)
        |=> cmd_o.valid && cmd_o.nbytes == 8'h02 ##1 !cmd_o.valid)
        else $error("word command not executed once");
endmodule : psm_top

// ===== sim/psm_host.sv
// host bus master model: start, stop and byte transfers on the shared line
`timescale 1ns/1ps
module psm_host (
    input wire logic mclk_i,
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic low = 1'b0;
    initial scl_o = 1'b1;
    assign sda_o = ~(low | sda_oe_i); // wired line with pull-up
    task automatic hp(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : hp
    task automatic start();
        low <= 1'b0;
        hp(10);
        scl_o <= 1'b1;
        hp(10);
        low <= 1'b1;
        hp(10);
        scl_o <= 1'b0;
        hp(2);
    endtask : start
    task automatic stop();
        low <= 1'b1;
        hp(10);
        scl_o <= 1'b1;
        hp(10);
        low <= 1'b0;
        hp(20);
    endtask : stop
    task automatic bitx(input logic b, output logic r);
        low <= ~b;
        hp(10);
        scl_o <= 1'b1;
        hp(5);
        @(negedge mclk_i);
        r = sda_o;
        hp(5);
        scl_o <= 1'b0;
        hp(2);
    endtask : bitx
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(last, r);
    endtask : rbyte
endmodule : psm_host

// ===== sim/psm_top_tb.sv
// self-checking bench for the supply management block
`timescale 1ns/1ps
`include "psm_defs.svh"
module psm_top_tb import psm_pkg::*;;
    localparam int TOUT = 200;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] sel = 3'h0;
    logic in_ok = 1'b0;
    logic rv = 1'b0;
    logic ew = 1'b0;
    logic es = 1'b0;
    logic blk_mode = 1'b0;
    psm_temps_t temps = '0;
    logic scl;
    logic sda;
    logic sda_oe;
    logic sda_lvl;
    logic al_n;
    logic al_oe;
    psm_therm_t th;
    psm_cmd_t cmd;
    psm_blk_t blk;
    psm_cmd_t cmd_q[$];
    logic [7:0] blk_q[$];
    logic [7:0] bb[4];
    int failures = 0;
    int cmp_count = 0;
    int seed = 32'hAACB34F3;
    psm_host host (.mclk_i(mclk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    psm_top #(.TOUT_CYCLES(TOUT), .AUX_MASK(3'h4)) dut (
        .mclk_i(mclk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_lvl),
        .sda_oe_o(sda_oe),
        .addr_sel_bit0_i(sel[0]), .addr_sel_bit1_i(sel[1]), .addr_sel_bit2_i(sel[2]),
        .in_ok_variant_i(in_ok), .reverse_airflow_i(rv), .temps_i(temps), .ext_warn_i(ew),
        .ext_shut_i(es), .fault_alert_n_o(al_n), .fault_alert_n_oe_o(al_oe), .therm_o(th),
        .cmd_o(cmd), .blk_o(blk));
    initial forever #5 mclk = ~mclk;
    task automatic stop_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic cmp_val(input logic [31:0] g, input logic [31:0] e, input string w);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %0t %s got %h exp %h", $time, w, g, e);
        end
    endtask : cmp_val
    task automatic cmp_cmd(input psm_cmd_t g, input psm_cmd_t e);
        if (e.valid) cmp_val({g.code, g.data, g.nbytes}, {e.code, e.data, e.nbytes}, "cmd");
        else cmp_val({g.code, g.nbytes}, {e.code, e.nbytes}, "send byte");
    endtask : cmp_cmd
    function automatic logic [15:0] edge4(input logic [15:0] w, input logic [15:0] s, int i);
        return (i < 2) ? w - 16'(1 - i) : s + 16'(i - 2);
    endfunction : edge4
    task automatic tcase(input logic [15:0] ti, tx, ty, input logic r, e1, e2);
        logic [2:0] w;
        logic [2:0] s;
        logic [2:0] ind;
        logic al;
        w[0] = ti >= (r ? `PSM_INLET_WARN_REV : `PSM_INLET_WARN_NORM);
        s[0] = ti > (r ? `PSM_INLET_SHUT_REV : `PSM_INLET_SHUT_NORM);
        w[2:1] = {ty >= `PSM_HOT_WARN, tx >= `PSM_HOT_WARN};
        s[2:1] = {ty > `PSM_HOT_SHUT, tx > `PSM_HOT_SHUT};
        al = |{w, s, e1, e2};
        @(posedge mclk);
        temps <= '{rectifier: ty, heatsink: tx, inlet: ti};
        rv <= r;
        ew <= e1;
        es <= e2;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        ind = {th.led_amber_solid, th.led_amber_blink, th.power_good_out};
        cmp_val({th.warn, th.shut}, {w, s}, "thresholds");
        cmp_val(th.fan_max, |w, "fan");
        cmp_val({th.main_off, th.stby_off}, {|s[1:0], s[2]}, "disable");
        cmp_val({al_oe, al_n, th.alert_on}, {al, 1'b0, al}, "alert");
        if (!e1 && !e2) cmp_val(ind, {|s, |w & ~|s, ~|s}, "indicator");
    endtask : tcase
    task automatic wr(input logic [7:0] ad, input logic [7:0] c, input int n);
        logic a;
        host.start();
        host.wbyte(ad, a);
        cmp_val(a, 1'b1, "address ack");
        host.wbyte(c, a);
        for (int k = 0; k < n; k++) begin
            host.wbyte(bb[k], a);
        end
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] ad, c, c2, input logic m, two, output logic [15:0] v);
        logic a;
        host.start();
        host.wbyte(ad, a);
        host.wbyte(c, a);
        if (m) host.wbyte(c2, a);
        host.start();
        host.wbyte(ad | 8'h01, a);
        cmp_val(a, 1'b1, "read ack");
        v = '0;
        host.rbyte(!two, v[7:0]);
        if (two) host.rbyte(1'b1, v[15:8]);
        host.stop();
    endtask : rd
    always @(negedge mclk) begin
        if (rstn && cmd.valid === 1'b1) begin
            if (blk_mode) cmp_val(cmd.code, 8'h3C, "block code");
            else if (cmd_q.size() == 0) cmp_val(1, 0, "stray command");
            else cmp_cmd(cmd, cmd_q.pop_front());
        end
        if (rstn && blk.valid === 1'b1) begin
            cmp_val(blk.data, blk_q.size() ? blk_q.pop_front() : 9'h100, "block");
        end
    end
    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        $display("mismatch %0t run too long", $time);
        stop_test();
    end
    initial begin
        logic a;
        logic [7:0] lo;
        logic [7:0] o;
        logic [7:0] ca;
        logic [7:0] ea;
        logic [15:0] v;
        logic [7:0] dv[3];
        repeat (4) @(posedge mclk);
        cmp_val({sda_lvl, sda_oe, al_oe, th}, '0, "reset state");
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            tcase(edge4(i[2] ? `PSM_INLET_WARN_REV : `PSM_INLET_WARN_NORM,
                i[2] ? `PSM_INLET_SHUT_REV : `PSM_INLET_SHUT_NORM, i % 4),
                edge4(`PSM_HOT_WARN, `PSM_HOT_SHUT, i % 4),
                edge4(`PSM_HOT_WARN, `PSM_HOT_SHUT, 3 - i % 4), i[2], 1'b0, 1'b0);
        end
        tcase(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 24; i++) begin
            tcase(16'($random(seed)) & 16'h007F, 16'($random(seed)) & 16'h007F,
                16'($random(seed)) & 16'h007F, 1'($random(seed)), 1'($random(seed)),
                1'($random(seed)));
        end
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk);
            sel <= 3'($random(seed)) | {p[0], 2'b00};
            in_ok <= p[0];
            repeat (10) @(posedge mclk);
            o = {4'h0, sel[2] & ~in_ok, sel[1:0], 1'b0};
            ca = `PSM_CTRL_BASE + o;
            ea = `PSM_EEP_BASE + o;
            host.start();
            for (int k = 7; k >= 0; k--) host.bitx(ca[k], a);
            repeat (8) @(negedge mclk);
            cmp_val(sda_oe, 1'b1, "ack held");
            repeat (TOUT + 60) @(negedge mclk);
            cmp_val(sda_oe, 1'b0, "timeout release");
            host.stop();
            host.start();
            host.wbyte(ca ^ (p ? 8'h08 : 8'h02), a);
            cmp_val(a, 1'b0, "foreign address");
            host.stop();
            for (int n = 0; n < 3; n++) begin
                bb[0] = 8'($random(seed));
                bb[1] = 8'($random(seed));
                cmd_q.push_back('{n > 0, 8'h3A, n == 2 ? {bb[1], bb[0]} : {8'h00, bb[0]}, 8'(n)});
                wr(ca, 8'h3A, n);
            end
            host.start();
            host.wbyte(ca, a);
            host.wbyte(8'h3A, a);
            // command byte is complete before the cut, so it runs as a send byte
            cmd_q.push_back('{1'b0, 8'h3A, 16'h0000, 8'h00});
            for (int k = 0; k < 4; k++) host.bitx(1'b0, a);
            host.stop();
            host.start();
            host.wbyte(ca, a);
            for (int k = 0; k < 3; k++) host.bitx(1'b1, a);
            cmd_q.push_back('{1'b1, 8'h3A, {8'h00, bb[0]}, 8'h01});
            wr(ca, 8'h3A, 1);
            for (int k = 0; k < 4; k++) bb[k] = 8'($random(seed));
            blk_mode = 1'b1;
            blk_q.push_back(bb[2]);
            blk_q.push_back(bb[3]);
            wr(ca, 8'h3C, 4);
            repeat (10) @(posedge mclk);
            blk_mode = 1'b0;
            for (int j = 0; j < 3; j++) begin
                lo = j == 0 ? `PSM_CMD_INLET : j == 1 ? `PSM_CMD_HEATSINK : `PSM_CMD_RECT;
                rd(ca, lo, 8'h00, 1'b0, j < 2, v);
                cmp_val(v, j == 2 ? {8'h00, temps.rectifier[7:0]} : j ? temps.heatsink
                    : temps.inlet, "temperature");
            end
            for (int k = 0; k < 3; k++) begin
                bb[0] = k == 2 ? 8'hFF : 8'(k * 92);
                bb[1] = 8'($random(seed));
                dv[k] = bb[1];
                wr(ea, 8'h00, 2);
                host.hp(50);
            end
            for (int k = 0; k < 3; k++) begin
                rd(ea, 8'h00, k == 2 ? 8'hFF : 8'(k * 92), 1'b1, 1'b0, v);
                cmp_val(v, {8'h00, dv[k]}, "memory");
            end
        end
        repeat (20) @(posedge mclk);
        cmp_val(cmd_q.size() + blk_q.size(), 0, "pending notes");
        stop_test();
    end
endmodule : psm_top_tb
